// ==== pmx_port_ef.sv ====
// Overview of operation
// - receiver enabled forces receive pin to input regardless of direction bit
// - forced receive pin pulls up when value bit one and global disable clear
// - bit 0 input enabled when pin-change source 8 mask and group enable set
// - bits 7..4 no pull/dir override; interrupts force input; timer outputs on 5,4
// - transmitter drives bit 1 output without pull-up; sync clock drives bit 2
// - test port enabled keeps pull-ups on tdi, tms, tck, even through reset
// - port f bit 7 is test data in, not general io while enabled
// - test data out floats except while shifting out
// - port f bit 5 is mode select, not general io while enabled
// - test port runs on test clock from port f bit 4
// - front-end enable drives rx/tx indicator on port f bit 3
// - port f bit 2 is analog channel 2 or antenna diversity output
// - test port pull-ups on for 7,5,4, off for 6; tdo driven only shifting
// - antenna switch enable forces bit 2 output with diversity signal
// - global pull-up disable kills every pull-up except the test port pull-ups on port f 7,5,4
//
// top: override logic for port e and port f 7..2
// assumes peripheral controls on clk; pins are asynchronous; test clock sampled as data
`timescale 1ns/1ps
`include "pmx_defines.svh"
module pmx_port_ef (
    input wire logic clk,
    input wire logic rst,
    input wire logic global_pullup_disable,
    input wire logic [7:0] porte_value,
    input wire logic [7:0] porte_direction,
    input wire logic [7:0] portf_value,
    input wire logic [7:0] portf_direction,
    input wire logic serial0_receiver_enable,
    input wire logic serial0_transmitter_enable,
    input wire logic serial0_transmit_data,
    input wire logic serial0_sync_clock_out_enable,
    input wire logic serial0_sync_clock,
    input wire logic timer3_compare_out_a_enable,
    input wire logic timer3_compare_out_a,
    input wire logic timer3_compare_out_b_enable,
    input wire logic timer3_compare_out_b,
    input wire logic timer3_compare_out_c_enable,
    input wire logic timer3_compare_out_c,
    input wire logic [3:0] ext_interrupt_enable,
    input wire logic pin_change_source_8,
    input wire logic pin_change_group1_enable,
    input wire logic test_port_enable,
    input wire logic shifting_instruction_reg,
    input wire logic shifting_data_reg,
    input wire logic test_data_out,
    input wire logic ext_frontend_enable,
    input wire logic radio_rxtx_indicator_alt,
    input wire logic antenna_switch_enable,
    input wire logic antenna_diversity_out_alt,
    input wire logic [7:0] porte_pin_in,
    input wire logic [7:0] portf_pin_in,
    output logic [7:0] porte_pin_out,
    output logic [7:0] porte_pin_oe,
    output logic [7:0] porte_pin_pullup,
    output logic [7:0] portf_pin_out,
    output logic [7:0] portf_pin_oe,
    output logic [7:0] portf_pin_pullup,
    output logic [7:0] porte_digital_in,
    output logic [7:0] portf_digital_in,
    output logic serial0_receive_data,
    output logic serial0_sync_clock_in,
    output logic timer3_capture_trigger,
    output logic timer3_count_input,
    output logic [3:0] ext_interrupt_in,
    output logic pin_change_8_in,
    output logic test_data_in,
    output logic test_mode_select,
    output logic test_clock
);
    pmx_ovr_if e_if ();
    pmx_ovr_if f_if ();
    pmx_pkg::pmx_ovr_s e_ov, f_ov;
    logic [7:0] e_din, f_din;
    logic [7:0] pe_out, pe_oe, pe_pu, pf_out, pf_oe, pf_pu;

    ////////////////////////////////////////////////////////////////////////
    // port e override table
    always_comb begin
        e_ov = '0;
        // receive pin: input, pull-up follows value unless globally disabled
        e_ov.pullup_override_enable[`PMX_PE_RX] = serial0_receiver_enable;
        e_ov.pullup_override_value[`PMX_PE_RX] = porte_value[`PMX_PE_RX] & ~global_pullup_disable;
        e_ov.direction_override_enable[`PMX_PE_RX] = serial0_receiver_enable;
        e_ov.direction_override_value[`PMX_PE_RX] = 1'b0;
        e_ov.input_enable_override_enable[`PMX_PE_RX] = pin_change_source_8 & pin_change_group1_enable;
        e_ov.input_enable_override_value[`PMX_PE_RX] = 1'b1;
        // transmit pin: output, no pull-up
        e_ov.pullup_override_enable[`PMX_PE_TX] = serial0_transmitter_enable;
        e_ov.direction_override_enable[`PMX_PE_TX] = serial0_transmitter_enable;
        e_ov.direction_override_value[`PMX_PE_TX] = 1'b1;
        e_ov.port_value_override_enable[`PMX_PE_TX] = serial0_transmitter_enable;
        e_ov.port_value_override_value[`PMX_PE_TX] = serial0_transmit_data;
        // sync clock output
        e_ov.direction_override_enable[`PMX_PE_XCK] = serial0_sync_clock_out_enable;
        e_ov.direction_override_value[`PMX_PE_XCK] = 1'b1;
        e_ov.port_value_override_enable[`PMX_PE_XCK] = serial0_sync_clock_out_enable;
        e_ov.port_value_override_value[`PMX_PE_XCK] = serial0_sync_clock;
        // compare a keeps the direction bit; software sets it
        e_ov.port_value_override_enable[`PMX_PE_OCA] = timer3_compare_out_a_enable;
        e_ov.port_value_override_value[`PMX_PE_OCA] = timer3_compare_out_a;
        e_ov.port_value_override_enable[`PMX_PE_OCB] = timer3_compare_out_b_enable;
        e_ov.port_value_override_value[`PMX_PE_OCB] = timer3_compare_out_b;
        e_ov.port_value_override_enable[`PMX_PE_OCC] = timer3_compare_out_c_enable;
        e_ov.port_value_override_value[`PMX_PE_OCC] = timer3_compare_out_c;
        // external interrupts force the input buffer on, bits 7..4
        for (int i = 0; i < 4; i++) begin
            e_ov.input_enable_override_enable[`PMX_PE_OCB + i] = ext_interrupt_enable[i];
            e_ov.input_enable_override_value[`PMX_PE_OCB + i] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port f override table; test pull-ups hold regardless of rst
    always_comb begin
        f_ov = '0;
        for (int i = `PMX_PF_TCK; i <= `PMX_PF_TDI; i++) begin
            f_ov.pullup_override_enable[i] = test_port_enable;
            f_ov.direction_override_enable[i] = test_port_enable;
            f_ov.input_enable_override_enable[i] = test_port_enable; // digital buffer off, analog path kept
        end
        f_ov.pullup_override_value[`PMX_PF_TDI] = 1'b1;
        f_ov.pullup_override_value[`PMX_PF_TMS] = 1'b1;
        f_ov.pullup_override_value[`PMX_PF_TCK] = 1'b1;
        f_ov.direction_override_value[`PMX_PF_TDO] = shifting_instruction_reg | shifting_data_reg;
        f_ov.port_value_override_enable[`PMX_PF_TDO] = test_port_enable;
        f_ov.port_value_override_value[`PMX_PF_TDO] = test_data_out;
        f_ov.direction_override_enable[`PMX_PF_RXTX] = ext_frontend_enable;
        f_ov.direction_override_value[`PMX_PF_RXTX] = ext_frontend_enable;
        f_ov.port_value_override_enable[`PMX_PF_RXTX] = ext_frontend_enable;
        f_ov.port_value_override_value[`PMX_PF_RXTX] = radio_rxtx_indicator_alt;
        f_ov.direction_override_enable[`PMX_PF_DIV] = antenna_switch_enable;
        f_ov.direction_override_value[`PMX_PF_DIV] = antenna_switch_enable;
        f_ov.port_value_override_enable[`PMX_PF_DIV] = antenna_switch_enable;
        f_ov.port_value_override_value[`PMX_PF_DIV] = antenna_diversity_out_alt;
    end

    assign e_if.ovr = e_ov;
    assign f_if.ovr = f_ov;

    pmx_pin_mux #(.W(`PMX_PORTE_W)) u_pe (
        .clk(clk),
        .rst(rst),
        .ov(e_if),
        .port_value(porte_value),
        .port_direction(porte_direction),
        .global_pullup_disable(global_pullup_disable),
        .pin_in(porte_pin_in),
        .pin_out(pe_out),
        .pin_oe(pe_oe),
        .pin_pullup(pe_pu),
        .pin_din(e_din)
    );

    pmx_pin_mux #(.W(`PMX_PORTF_W)) u_pf (
        .clk(clk),
        .rst(rst),
        .ov(f_if),
        .port_value(portf_value),
        .port_direction(portf_direction),
        .global_pullup_disable(global_pullup_disable),
        .pin_in(portf_pin_in),
        .pin_out(pf_out),
        .pin_oe(pf_oe),
        .pin_pullup(pf_pu),
        .pin_din(f_din)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin outputs; the mux keeps override pull-ups through reset, so test pull-ups survive it
    assign porte_pin_out = pe_out;
    assign porte_pin_oe = pe_oe;
    assign porte_pin_pullup = pe_pu;
    assign portf_pin_out = pf_out;
    assign portf_pin_oe = pf_oe;
    assign portf_pin_pullup = pf_pu;
    assign porte_digital_in = e_din;
    assign portf_digital_in = f_din;

    // peripheral taps; test pins bypass the gated buffer and get their own synchroniser below
    assign serial0_receive_data = e_din[`PMX_PE_RX];
    assign pin_change_8_in = e_din[`PMX_PE_RX];
    assign serial0_sync_clock_in = e_din[`PMX_PE_XCK];
    assign timer3_capture_trigger = e_din[`PMX_PE_ICP];
    assign timer3_count_input = e_din[`PMX_PE_T3];
    assign ext_interrupt_in = e_din[7:4];

    logic tdi_r, tms_r, tck_r;
    logic [7:0] tsync1_r, tsync2_r;
    // test pins need their own two-flop synchroniser: the mux gates their digital input off
    always_ff @(posedge clk) begin
        if (rst) begin
            tdi_r <= 1'b0;
            tms_r <= 1'b0;
            tck_r <= 1'b0;
            tsync1_r <= '0;
            tsync2_r <= '0;
        end else begin
            tsync1_r <= portf_pin_in;
            tsync2_r <= tsync1_r;
            tdi_r <= tap_bit(tsync2_r, `PMX_PF_TDI);
            tms_r <= tap_bit(tsync2_r, `PMX_PF_TMS);
            tck_r <= tap_bit(tsync2_r, `PMX_PF_TCK);
        end
    end

    // picks one synchronised test pin; held low while the test port is off
    function automatic logic tap_bit(input logic [7:0] v, input int b);
        tap_bit = v[b[2:0]] & test_port_enable;
    endfunction

    assign test_data_in = tdi_r;
    assign test_mode_select = tms_r;
    assign test_clock = tck_r;
endmodule

// ==== pmx_defines.svh ====
// pin override constants for port e and upper port f
// assumes inclusion by bare name from design files
`ifndef PMX_DEFINES_SVH
`define PMX_DEFINES_SVH
`define PMX_PORTE_W 8
`define PMX_PORTF_W 8
`define PMX_PE_RX 0
`define PMX_PE_TX 1
`define PMX_PE_XCK 2
`define PMX_PE_OCA 3
`define PMX_PE_OCB 4
`define PMX_PE_OCC 5
`define PMX_PE_T3 6
`define PMX_PE_ICP 7
`define PMX_PF_DIV 2
`define PMX_PF_RXTX 3
`define PMX_PF_TCK 4
`define PMX_PF_TMS 5
`define PMX_PF_TDO 6
`define PMX_PF_TDI 7
`define PMX_RST_BYTE 8'h00
`endif

// ==== pmx_pkg.sv ====
// shared types for the pin override block
// assumes no other package
package pmx_pkg;
    typedef logic [7:0] pmx_byte_t;
    // per-pin override enables and values for one port
    typedef struct packed {
        logic [7:0] pullup_override_enable;
        logic [7:0] pullup_override_value;
        logic [7:0] direction_override_enable;
        logic [7:0] direction_override_value;
        logic [7:0] port_value_override_enable;
        logic [7:0] port_value_override_value;
        logic [7:0] input_enable_override_enable;
        logic [7:0] input_enable_override_value;
    } pmx_ovr_s;
endpackage

// ==== pmx_ovr_if.sv ====
// carrier for one port's override set between the modules
// assumes one clock domain
`timescale 1ns/1ps
interface pmx_ovr_if;
    pmx_pkg::pmx_ovr_s ovr;
    modport src (output ovr);
    modport dst (input ovr);
endinterface

// ==== pmx_pin_mux.sv ====
// generic per-pin override merge for one eight-bit port
// assumes port registers and overrides on clk; pin inputs raw
`timescale 1ns/1ps
`include "pmx_defines.svh"
module pmx_pin_mux #(
    parameter int W = `PMX_PORTE_W
) (
    input wire logic clk,
    input wire logic rst,
    pmx_ovr_if.dst ov,
    input wire logic [W-1:0] port_value,
    input wire logic [W-1:0] port_direction,
    input wire logic global_pullup_disable,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pin_pullup,
    output logic [W-1:0] pin_din
);
    logic [W-1:0] out_r, out_nxt, oe_r, oe_nxt, pu_r, pu_nxt, din_r, din_nxt;
    logic [W-1:0] sync1_r, sync2_r;
    logic [W-1:0] die;

    ////////////////////////////////////////////////////////////////////////
    // merge: override wins when its enable is set
    always_comb begin
        for (int i = 0; i < W; i++) begin
            oe_nxt[i] = ov.ovr.direction_override_enable[i] ? ov.ovr.direction_override_value[i] : port_direction[i];
            out_nxt[i] = ov.ovr.port_value_override_enable[i] ? ov.ovr.port_value_override_value[i] : port_value[i];
            // default pull-up is {dir,val}=01 with the global disable clear
            pu_nxt[i] = ov.ovr.pullup_override_enable[i] ? ov.ovr.pullup_override_value[i]
                : (~port_direction[i] & port_value[i] & ~global_pullup_disable);
            die[i] = ov.ovr.input_enable_override_enable[i] ? ov.ovr.input_enable_override_value[i] : 1'b1;
            // input read after two flops, gated by its enable
            din_nxt[i] = sync2_r[i] & die[i];
        end
    end

    // registers; sync1 feeds only sync2
    always_ff @(posedge clk) begin
        if (rst) begin
            out_r <= '0;
            oe_r <= '0;
            // pull-up overrides are held through reset, so the test port keeps its pull-ups
            pu_r <= W'(ov.ovr.pullup_override_enable & ov.ovr.pullup_override_value);
            din_r <= '0;
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            pu_r <= pu_nxt;
            din_r <= din_nxt;
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    assign pin_out = out_r;
    assign pin_oe = oe_r;
    assign pin_pullup = pu_r;
    assign pin_din = din_r;
endmodule

// ==== pmx_port_ef_checker.sv ====
// concurrent checks on the port e/f override outputs
// assumes binding into pmx_port_ef; one clock, sync reset
`timescale 1ns/1ps
module pmx_port_ef_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic global_pullup_disable,
    input wire logic [7:0] porte_value,
    input wire logic [7:0] porte_direction,
    input wire logic serial0_receiver_enable,
    input wire logic serial0_transmitter_enable,
    input wire logic serial0_transmit_data,
    input wire logic test_port_enable,
    input wire logic shifting_instruction_reg,
    input wire logic shifting_data_reg,
    input wire logic test_data_out,
    input wire logic ext_frontend_enable,
    input wire logic radio_rxtx_indicator_alt,
    input wire logic [7:0] porte_pin_oe,
    input wire logic [7:0] porte_pin_pullup,
    input wire logic [7:0] porte_pin_out,
    input wire logic [7:0] portf_pin_out,
    input wire logic [7:0] portf_pin_oe,
    input wire logic [7:0] portf_pin_pullup
);
    logic live_r;
    logic live_nxt;
    // first edge after reset still shows reset outputs, so skip it
    always_comb live_nxt = 1'h1;
    always_ff @(posedge clk) begin
        live_r <= rst ? 1'h0 : live_nxt;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // a control seen one edge ago, once outputs are live
    sequence s_was(e);
        live_r && $past(e);
    endsequence
    property p_rx_dir; s_was(serial0_receiver_enable) |-> !porte_pin_oe[0]; endproperty
    a_rx_dir: assert property (p_rx_dir) else $error("receive pin driven");
    property p_rx_pull;
        s_was(serial0_receiver_enable) |-> porte_pin_pullup[0] == $past(porte_value[0] && !global_pullup_disable);
    endproperty
    a_rx_pull: assert property (p_rx_pull) else $error("receive pull-up wrong");
    property p_tx;
        s_was(serial0_transmitter_enable) |-> porte_pin_oe[1] && !porte_pin_pullup[1]
            && porte_pin_out[1] == $past(serial0_transmit_data);
    endproperty
    a_tx: assert property (p_tx) else $error("transmit pin wrong");
    property p_e_dir; s_was(1'h1) |-> porte_pin_oe[7:4] == $past(porte_direction[7:4]); endproperty
    a_e_dir: assert property (p_e_dir) else $error("upper port e direction overridden");
    property p_tap_pull; s_was(test_port_enable) |-> portf_pin_pullup[7:4] == 4'hb; endproperty
    a_tap_pull: assert property (p_tap_pull) else $error("test pin pull-ups wrong");
    property p_tdo;
        s_was(test_port_enable) |-> portf_pin_oe[7:4] == {1'h0, $past(shifting_instruction_reg | shifting_data_reg), 2'h0}
            && (!portf_pin_oe[6] || portf_pin_out[6] == $past(test_data_out));
    endproperty
    a_tdo: assert property (p_tdo) else $error("test pin drive wrong");
    property p_gpd;
        s_was(global_pullup_disable && !test_port_enable) |-> (porte_pin_pullup | portf_pin_pullup) == 8'h00;
    endproperty
    a_gpd: assert property (p_gpd) else $error("pull-up while disabled");
    property p_fe;
        s_was(ext_frontend_enable) |-> portf_pin_oe[3] && portf_pin_out[3] == $past(radio_rxtx_indicator_alt);
    endproperty
    a_fe: assert property (p_fe) else $error("front-end indicator wrong");
endmodule
bind pmx_port_ef pmx_port_ef_checker i_pmx_port_ef_checker (.*);

// ==== pmx_board_model.sv ====
// board side of one eight-pin port: drivers, pull-ups, floating lines
// assumes the board drives only pins the device has released
`timescale 1ns/1ps
module pmx_board_model (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] drv,
    input wire logic [7:0] val,
    output logic [7:0] pin_in
);
    logic [7:0] flt_r = 8'h55;
    // floating lines toggle so a stale level never reads as valid
    always_ff @(posedge clk) flt_r <= ~flt_r;
    // device drive wins, then board drive, then pull-up, else float
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv & val) | (~pin_oe & ~drv & (pin_pullup | flt_r));
endmodule

// ==== pmx_port_ef_tb_top.sv ====
// self-checking bench for the port e/f override block
// assumes design outputs one edge behind inputs, pin taps a few edges behind
`timescale 1ns/1ps
module pmx_port_ef_tb_top;
    logic clk = 1'h0, rst = 1'h1, global_pullup_disable = 1'h0;
    logic [7:0] porte_value = 8'h00, porte_direction = 8'h00, portf_value = 8'h00, portf_direction = 8'h00;
    logic serial0_receiver_enable = 1'h0, serial0_transmitter_enable = 1'h0, serial0_transmit_data = 1'h0;
    logic serial0_sync_clock_out_enable = 1'h0, serial0_sync_clock = 1'h0, pin_change_source_8 = 1'h0;
    logic timer3_compare_out_a_enable = 1'h0, timer3_compare_out_a = 1'h0, timer3_compare_out_b_enable = 1'h0;
    logic timer3_compare_out_b = 1'h0, timer3_compare_out_c_enable = 1'h0, timer3_compare_out_c = 1'h0;
    logic pin_change_group1_enable = 1'h0, test_port_enable = 1'h0, shifting_instruction_reg = 1'h0;
    logic shifting_data_reg = 1'h0, test_data_out = 1'h0, ext_frontend_enable = 1'h0, radio_rxtx_indicator_alt = 1'h0;
    logic antenna_switch_enable = 1'h0, antenna_diversity_out_alt = 1'h0;
    logic [3:0] ext_interrupt_enable = 4'h0, ext_interrupt_in;
    logic [7:0] porte_pin_in, portf_pin_in, porte_pin_out, porte_pin_oe, porte_pin_pullup, portf_pin_out;
    logic [7:0] portf_pin_oe, portf_pin_pullup, porte_digital_in, portf_digital_in, v;
    logic [7:0] e_drv = 8'h00, e_val = 8'h00, f_drv = 8'h00, f_val = 8'h00;
    logic serial0_receive_data, serial0_sync_clock_in, timer3_capture_trigger, timer3_count_input;
    logic pin_change_8_in, test_data_in, test_mode_select, test_clock;
    int bad_count = 0, comparisons = 0;
    ////////////////////////////////////////////////////////////////
    pmx_port_ef i_pmx_port_ef (.*);
    pmx_board_model i_pmx_board_model_e (.clk(clk), .pin_out(porte_pin_out), .pin_oe(porte_pin_oe),
        .pin_pullup(porte_pin_pullup), .drv(e_drv), .val(e_val), .pin_in(porte_pin_in));
    pmx_board_model i_pmx_board_model_f (.clk(clk), .pin_out(portf_pin_out), .pin_oe(portf_pin_oe),
        .pin_pullup(portf_pin_pullup), .drv(f_drv), .val(f_val), .pin_in(portf_pin_in));
    // 125 mhz clock
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // fixed latencies only, then step off the edge to sample
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        settle(3);
        // plain port behaviour, then global pull-up kill; stimulus changes on an edge
        @(posedge clk);
        porte_value <= 8'h3c;
        porte_direction <= 8'h0f;
        portf_value <= 8'h3c;
        portf_direction <= 8'h0f;
        settle(2);
        check(porte_pin_out, 8'h3c);
        check(porte_pin_oe, 8'h0f);
        check(porte_pin_pullup, 8'h30);
        check(portf_pin_pullup, 8'h30);
        @(posedge clk);
        global_pullup_disable <= 1'h1;
        settle(2);
        check(porte_pin_pullup | portf_pin_pullup, 8'h00);
        // inputs reach digital inputs and every peripheral tap
        @(posedge clk);
        porte_direction <= 8'h00;
        global_pullup_disable <= 1'h0;
        ext_interrupt_enable <= 4'hf;
        pin_change_source_8 <= 1'h1;
        pin_change_group1_enable <= 1'h1;
        e_drv <= 8'hff;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            v = i ? 8'h5a : 8'ha5;
            e_val <= v;
            settle(5);
            check(porte_digital_in, v);
            check({ext_interrupt_in, timer3_capture_trigger, timer3_count_input, serial0_sync_clock_in,
                serial0_receive_data}, {v[7:4], v[7], v[6], v[2], v[0]});
            check({7'h00, pin_change_8_in}, {7'h00, v[0]});
        end
        // serial receiver, transmitter and sync clock take bits 0..2
        @(posedge clk);
        e_drv <= 8'h00;
        porte_direction <= 8'hff;
        porte_value <= 8'h01;
        serial0_receiver_enable <= 1'h1;
        serial0_transmitter_enable <= 1'h1;
        serial0_sync_clock_out_enable <= 1'h1;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            serial0_transmit_data <= !i;
            serial0_sync_clock <= i[0];
            settle(2);
            check(porte_pin_oe, 8'hfe);
            check(porte_pin_out, i ? 8'h05 : 8'h03);
            check(porte_pin_pullup, 8'h01);
        end
        // timer compare outputs replace the port value
        @(posedge clk);
        serial0_receiver_enable <= 1'h0;
        serial0_transmitter_enable <= 1'h0;
        serial0_sync_clock_out_enable <= 1'h0;
        timer3_compare_out_a_enable <= 1'h1;
        timer3_compare_out_b_enable <= 1'h1;
        timer3_compare_out_c_enable <= 1'h1;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            porte_value <= i ? 8'hff : 8'h00;
            timer3_compare_out_a <= !i;
            timer3_compare_out_b <= i[0];
            timer3_compare_out_c <= !i;
            settle(2);
            check(porte_pin_out, i ? 8'hd7 : 8'h28);
        end
        // test port: of the test pins only data-out may drive, and only while shifting; bits 3..0 follow the direction bits
        @(posedge clk);
        test_port_enable <= 1'h1;
        portf_direction <= 8'hff;
        portf_value <= 8'h00; // port f outputs held steady
        f_drv <= 8'hb0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            v = (i == 0) ? 8'h90 : (i == 1) ? 8'h20 : 8'hb0;
            f_val <= v;
            shifting_instruction_reg <= (i == 0);
            shifting_data_reg <= (i == 1);
            test_data_out <= !i;
            settle(6);
            check(portf_pin_oe, i < 2 ? 8'h4f : 8'h0f);
            if (i < 2) check(portf_pin_out, i ? 8'h00 : 8'h40);
            check(portf_pin_pullup, 8'hb0);
            check(portf_digital_in, 8'h00);
            check({test_data_in, test_mode_select, test_clock, 5'h00}, {v[7], v[5], v[4], 5'h00});
        end
        // a reset in mid-run must not drop the test pull-ups
        @(posedge clk);
        rst <= 1'h1;
        settle(2);
        check(portf_pin_pullup, 8'hb0);
        check(portf_pin_oe, 8'h00);
        @(posedge clk);
        rst <= 1'h0;
        settle(3);
        check(portf_pin_pullup, 8'hb0);
        // radio front-end indicator and antenna diversity on bits 3 and 2
        @(posedge clk);
        test_port_enable <= 1'h0;
        f_drv <= 8'h00;
        portf_direction <= 8'h00;
        ext_frontend_enable <= 1'h1;
        antenna_switch_enable <= 1'h1;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            radio_rxtx_indicator_alt <= !i;
            antenna_diversity_out_alt <= i[0];
            settle(2);
            check(portf_pin_oe, 8'h0c);
            check(portf_pin_out, i ? 8'h04 : 8'h08);
        end
        end_of_test();
    end
endmodule
